// >>> rtl/mii_pkg.sv
// Shared types and constants for the media independent interface pin block.
// Assumes a 10 MHz system clock and PHY-supplied transmit and receive clocks.
package mii_pkg;

  localparam int CLK_KHZ = 10000;
  localparam int MDC_MAX_KHZ = 2500;
  // Half period of the management clock, rounded up so it never runs too fast.
  localparam int MDC_HALF_CYCLES = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);

  localparam int FRAME_BITS = 64;
  localparam int READ_DRIVE_BITS = 46;
  localparam int DATA_FIRST_BIT = 48;
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TURNAROUND = 2'h2;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [3:0] NIBBLE_IDLE = 4'h0;

  typedef struct packed {
    logic [3:0] nib;
    logic last;
    logic err;
  } nib_word_type;

  typedef struct packed {
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mgmt_cmd_type;

  localparam nib_word_type NIB_WORD_RESET = '0;

endpackage

// >>> rtl/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides; all outputs are registered.
// Assumes one clock and a synchronous active-low reset copy from the parent.
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  if (WIDTH < 1) begin : g_width_check
    $error("two_entry_buffer: WIDTH must be at least 1.");
  end

  logic out_valid_q, out_valid_d, skid_valid_q, skid_valid_d, in_ready_q;
  logic [WIDTH-1:0] out_data_q, out_data_d, skid_data_q, skid_data_d;
  logic accept;

  always_comb begin
    accept = in_valid && !skid_valid_q;
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    skid_valid_d = skid_valid_q;
    skid_data_d = skid_data_q;
    if (!out_valid_q || out_ready) begin
      if (skid_valid_q) begin
        out_valid_d = 1'b1;
        out_data_d = skid_data_q;
        skid_valid_d = 1'b0;
      end else begin
        out_valid_d = accept;
        out_data_d = in_data;
      end
    end else if (accept) begin
      // A stalled drain parks the word here instead of losing it.
      skid_valid_d = 1'b1;
      skid_data_d = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      skid_valid_q <= 1'b0;
      skid_data_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      skid_valid_q <= skid_valid_d;
      skid_data_q <= skid_data_d;
      // Ready is kept in a flop of its own so the port comes straight from a register.
      in_ready_q <= !skid_valid_d;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

endmodule // two_entry_buffer

// >>> rtl/mii_mac_pin_interface.sv
// Pin side of the Ethernet MAC: management channel, transmit and receive nibble paths.
// Assumes tx_clk and rx_clk come from the PHY and are unrelated to mclk.
`timescale 1ns/10ps
// Overview of operation
// - Device makes the management clock, never faster than 2.5 MHz.
// - Management data line is shared; each side drives only in its turn.
// - Transmit data leaves as a nibble bus clocked by the transmit clock.
// - Single-bit coding mode sends transmit data on bit 0 only.
// - Transmit coding error is raised when the outgoing stream is corrupt.
// - Transmit enable is high while transmit data is presented, and stays high with tx_er through an underrun inside a frame.
// - Receive nibbles are captured in the receive clock domain.
// - Single-bit coding mode takes receive data from bit 0 only.
module mii_mac_pin_interface (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic single_bit_serial_coding_mode,
  // Transmit words from the MAC core
  input wire logic tx_in_valid,
  input wire mii_pkg::nib_word_type tx_in_word,
  output logic tx_in_ready,
  // Receive words to the MAC core
  output logic rx_out_valid,
  output mii_pkg::nib_word_type rx_out_word,
  input wire logic rx_out_ready,
  // Management commands
  input wire logic mgmt_start,
  input wire mii_pkg::mgmt_cmd_type mgmt_cmd,
  output logic mgmt_busy,
  output logic mgmt_done,
  output logic [15:0] mgmt_rdata,
  // Line status
  output logic col_sync,
  output logic crs_sync,
  // Management pins
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // Transmit pins
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er,
  input wire logic col,
  input wire logic crs,
  // Receive pins
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er
);
  import mii_pkg::*;

  typedef enum logic {MG_IDLE, MG_SHIFT} mgmt_state_type;

  function automatic logic [3:0] lane_select(input logic one_bit, input logic [3:0] nib);
    lane_select = one_bit ? {3'h0, nib[0]} : nib;
  endfunction

  // Reset release, one synchronised copy per clock domain.
  logic rm1_q, rst_m_n, rt1_q, rst_t_n, rr1_q, rst_r_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rm1_q <= 1'b0;
      rst_m_n <= 1'b0;
    end else begin
      rm1_q <= 1'b1;
      rst_m_n <= rm1_q;
    end
  end
  always_ff @(posedge tx_clk or negedge rst_n) begin
    if (!rst_n) begin
      rt1_q <= 1'b0;
      rst_t_n <= 1'b0;
    end else begin
      rt1_q <= 1'b1;
      rst_t_n <= rt1_q;
    end
  end
  always_ff @(posedge rx_clk or negedge rst_n) begin
    if (!rst_n) begin
      rr1_q <= 1'b0;
      rst_r_n <= 1'b0;
    end else begin
      rr1_q <= 1'b1;
      rst_r_n <= rr1_q;
    end
  end

  // Pin synchronisers into mclk.
  logic col1_q, col_q, crs1_q, crs_q, md1_q, md_q;
  always_ff @(posedge mclk) begin
    if (!rst_m_n) begin
      {col1_q, col_q, crs1_q, crs_q, md1_q, md_q} <= '0;
    end else begin
      col1_q <= col;
      col_q <= col1_q;
      crs1_q <= crs;
      crs_q <= crs1_q;
      md1_q <= mdio_in;
      md_q <= md1_q;
    end
  end
  assign col_sync = col_q;
  assign crs_sync = crs_q;

  // Management engine.
  mgmt_state_type mst_q, mst_d;
  logic [1:0] div_q, div_d;
  logic [5:0] bit_q, bit_d;
  logic [63:0] sh_q, sh_d;
  logic [15:0] rd_q, rd_d;
  logic mdc_q, mdc_d, oe_n_q, oe_n_d, rdop_q, rdop_d, done_q, done_d, busy_q, busy_d;
  logic tick;

  always_comb begin
    mst_d = mst_q;
    div_d = div_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    mdc_d = mdc_q;
    oe_n_d = oe_n_q;
    rdop_d = rdop_q;
    done_d = 1'b0;
    tick = (div_q == 2'(MDC_HALF_CYCLES - 1));
    unique case (mst_q)
      MG_IDLE: begin
        if (mgmt_start) begin
          sh_d = {PREAMBLE, START_CODE, mgmt_cmd.write ? OP_WRITE : OP_READ,
                  mgmt_cmd.phy_addr, mgmt_cmd.reg_addr, TURNAROUND, mgmt_cmd.wdata};
          rdop_d = !mgmt_cmd.write;
          bit_d = '0;
          div_d = '0;
          mdc_d = 1'b0;
          oe_n_d = 1'b0;
          mst_d = MG_SHIFT;
        end
      end
      MG_SHIFT: begin
        div_d = tick ? 2'h0 : div_q + 2'h1;
        if (tick) begin
          mdc_d = !mdc_q;
          if (mdc_q) begin
            // Data changes on the falling edge so the PHY samples it mid-bit.
            // The two sync flops delay the pin by one mdc half period, so md_q now
            // shows the line as it stood at the rising edge of this bit.
            if (rdop_q && bit_q >= 6'(DATA_FIRST_BIT)) begin
              rd_d = {rd_q[14:0], md_q};
            end
            sh_d = {sh_q[62:0], 1'b0};
            bit_d = bit_q + 6'h1;
            if (rdop_q && bit_q == 6'(READ_DRIVE_BITS - 1)) begin
              oe_n_d = 1'b1;
            end
            if (bit_q == 6'(FRAME_BITS - 1)) begin
              oe_n_d = 1'b1;
              done_d = 1'b1;
              mst_d = MG_IDLE;
            end
          end
        end
      end
    endcase
    busy_d = (mst_d == MG_SHIFT);
  end

  always_ff @(posedge mclk) begin
    if (!rst_m_n) begin
      mst_q <= MG_IDLE;
      busy_q <= 1'b0;
      div_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      rd_q <= RDATA_RESET;
      mdc_q <= 1'b0;
      oe_n_q <= 1'b1;
      rdop_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      busy_q <= busy_d;
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      mdc_q <= mdc_d;
      oe_n_q <= oe_n_d;
      rdop_q <= rdop_d;
      done_q <= done_d;
    end
  end
  assign mdc = mdc_q;
  assign mdio_out = sh_q[63];
  assign mdio_oe_n = oe_n_q;
  assign mgmt_busy = busy_q;
  assign mgmt_done = done_q;
  assign mgmt_rdata = rd_q;

  // Transmit: buffer in mclk, then a toggle handshake per word into tx_clk.
  nib_word_type txb_word, txx_q, txx_d;
  logic txb_valid, txb_ready, txreq_q, txreq_d, ta1_q, ta2_q, tx_pend, txack_q;
  two_entry_buffer #(.WIDTH($bits(nib_word_type))) tx_buf (
    .clk(mclk),
    .rst_n(rst_m_n),
    .in_valid(tx_in_valid),
    .in_data(tx_in_word),
    .in_ready(tx_in_ready),
    .out_valid(txb_valid),
    .out_data(txb_word),
    .out_ready(txb_ready)
  );
  always_comb begin
    tx_pend = (txreq_q != ta2_q);
    txb_ready = !tx_pend;
    txx_d = txx_q;
    txreq_d = txreq_q;
    if (txb_valid && !tx_pend) begin
      txx_d = txb_word;
      txreq_d = !txreq_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_m_n) begin
      txx_q <= NIB_WORD_RESET;
      txreq_q <= 1'b0;
      ta1_q <= 1'b0;
      ta2_q <= 1'b0;
    end else begin
      txx_q <= txx_d;
      txreq_q <= txreq_d;
      ta1_q <= txack_q;
      ta2_q <= ta1_q;
    end
  end

  logic tr1_q, tr2_q, txack_d, tm1_q, tm2_q, act_q, act_d;
  logic [3:0] txd_q, txd_d;
  logic txen_q, txen_d, txer_q, txer_d;
  always_comb begin
    txack_d = txack_q;
    act_d = act_q;
    txd_d = NIBBLE_IDLE;
    txen_d = 1'b0;
    txer_d = 1'b0;
    if (tr2_q != txack_q) begin
      txack_d = tr2_q;
      txd_d = lane_select(tm2_q, txx_q.nib);
      txen_d = 1'b1;
      txer_d = txx_q.err;
      act_d = !txx_q.last;
    end else if (act_q) begin
      // Underrun inside a frame: keep the frame open and mark it corrupt.
      txen_d = 1'b1;
      txer_d = 1'b1;
    end
  end
  always_ff @(posedge tx_clk) begin
    if (!rst_t_n) begin
      {tr1_q, tr2_q, txack_q, tm1_q, tm2_q, act_q} <= '0;
      txd_q <= NIBBLE_IDLE;
      txen_q <= 1'b0;
      txer_q <= 1'b0;
    end else begin
      tr1_q <= txreq_q;
      tr2_q <= tr1_q;
      tm1_q <= single_bit_serial_coding_mode;
      tm2_q <= tm1_q;
      txack_q <= txack_d;
      act_q <= act_d;
      txd_q <= txd_d;
      txen_q <= txen_d;
      txer_q <= txer_d;
    end
  end
  assign txd = txd_q;
  assign tx_en = txen_q;
  assign tx_er = txer_q;

  // Receive: capture in rx_clk, hold one nibble to know which is last.
  logic [3:0] rxd_q;
  logic dv_q, er_q, rm1s_q, rm2_q, infr_q, hv_q, hv_d, ferr_q, ferr_d;
  logic rxreq_q, rxreq_d, ra1_q, ra2_q, rx_busy, emit, rxack_q;
  logic [3:0] hnib_q, hnib_d;
  nib_word_type rxx_q, rxx_d;
  always_comb begin
    rx_busy = (rxreq_q != ra2_q);
    hv_d = hv_q;
    hnib_d = hnib_q;
    ferr_d = ferr_q;
    rxreq_d = rxreq_q;
    rxx_d = rxx_q;
    emit = hv_q;
    if (dv_q) begin
      ferr_d = (infr_q ? ferr_q : 1'b0) | er_q;
      hv_d = 1'b1;
      hnib_d = lane_select(rm2_q, rxd_q);
    end else begin
      hv_d = 1'b0;
    end
    if (emit) begin
      if (rx_busy) begin
        ferr_d = 1'b1;
      end else begin
        rxx_d = '{nib: hnib_q, last: !dv_q, err: ferr_d};
        rxreq_d = !rxreq_q;
      end
    end
  end
  always_ff @(posedge rx_clk) begin
    if (!rst_r_n) begin
      rxd_q <= NIBBLE_IDLE;
      {dv_q, er_q, rm1s_q, rm2_q, infr_q, hv_q, ferr_q, rxreq_q, ra1_q, ra2_q} <= '0;
      hnib_q <= NIBBLE_IDLE;
      rxx_q <= NIB_WORD_RESET;
    end else begin
      rxd_q <= rxd;
      dv_q <= rx_dv;
      er_q <= rx_er;
      rm1s_q <= single_bit_serial_coding_mode;
      rm2_q <= rm1s_q;
      infr_q <= dv_q;
      hv_q <= hv_d;
      hnib_q <= hnib_d;
      ferr_q <= ferr_d;
      rxreq_q <= rxreq_d;
      rxx_q <= rxx_d;
      ra1_q <= rxack_q;
      ra2_q <= ra1_q;
    end
  end

  logic rq1_q, rq2_q, rxack_d, rxb_in_ready, rxb_in_valid;
  always_comb begin
    rxb_in_valid = (rq2_q != rxack_q);
    rxack_d = (rxb_in_valid && rxb_in_ready) ? rq2_q : rxack_q;
  end
  always_ff @(posedge mclk) begin
    if (!rst_m_n) begin
      {rq1_q, rq2_q, rxack_q} <= '0;
    end else begin
      rq1_q <= rxreq_q;
      rq2_q <= rq1_q;
      rxack_q <= rxack_d;
    end
  end
  two_entry_buffer #(.WIDTH($bits(nib_word_type))) rx_buf (
    .clk(mclk),
    .rst_n(rst_m_n),
    .in_valid(rxb_in_valid),
    .in_data(rxx_q),
    .in_ready(rxb_in_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_word),
    .out_ready(rx_out_ready)
  );

endmodule // mii_mac_pin_interface

// >>> verification/mii_pin_checker.sv
// Port assertions for the MII pin block.
// Assumes it is bound to every instance of that block.
`timescale 1ns/10ps
module mii_pin_checker (
  // Clocks and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tx_clk,
  // Watched ports
  input wire logic single_bit_serial_coding_mode,
  input wire logic mgmt_start,
  input wire logic mgmt_busy,
  input wire logic mgmt_done,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic col,
  input wire logic col_sync,
  input wire logic rx_out_valid,
  input wire logic rx_out_ready,
  input wire mii_pkg::nib_word_type rx_out_word
);
  import mii_pkg::*;
  logic [8:0] busy_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 9'h000;
    end else begin
      busy_q <= mgmt_busy ? busy_q + 9'h001 : 9'h000;
    end
  end
  sequence frame_open;
    mgmt_busy && !mdio_oe_n && mdio_out;
  endsequence
  mdc_half_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(mdc) |=> $stable(mdc)) else $error("mdc half period short");
  mdio_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !mgmt_busy && !$past(mgmt_busy) |-> mdio_oe_n) else $error("mdio driven while idle");
  frame_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mgmt_start && !mgmt_busy |=> frame_open) else $error("frame did not open");
  frame_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mgmt_done |-> busy_q inside {[9'h0FA:9'h104]}) else $error("frame length wrong");
  done_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mgmt_done |=> !mgmt_done) else $error("done longer than a cycle");
  tx_bit0_a: assert property (@(posedge tx_clk) disable iff (!rst_n)
    tx_en && single_bit_serial_coding_mode |-> txd[3:1] == 3'h0) else $error("upper txd used");
  tx_idle_a: assert property (@(posedge tx_clk) disable iff (!rst_n)
    !tx_en |-> txd == 4'h0 && !tx_er) else $error("txd active while disabled");
  col_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
    col [*4] |-> col_sync) else $error("collision not passed on");
  col_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !col [*4] |-> !col_sync) else $error("collision stuck");
  rx_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out_word))
    else $error("receive word lost in stall");
endmodule // mii_pin_checker

bind mii_mac_pin_interface mii_pin_checker i_chk (.mclk, .rst_n, .tx_clk,
  .single_bit_serial_coding_mode, .mgmt_start, .mgmt_busy, .mgmt_done, .mdc, .mdio_out,
  .mdio_oe_n, .txd, .tx_en, .tx_er, .col, .col_sync, .rx_out_valid, .rx_out_ready,
  .rx_out_word);

// >>> verification/mii_phy_model.sv
// Behavioural PHY: link clocks, transmit capture, receive frames, management answers.
// Assumes the bench resolves the management wire with a pull-up.
`timescale 1ns/10ps
module mii_phy_model #(
  parameter logic [15:0] READ_VALUE = 16'hA5C3
) (
  // Management
  input wire logic mdc,
  input wire logic mdio_oe_n,
  input wire logic mdio_wire,
  output logic phy_drive,
  output logic phy_bit,
  // Transmit
  output logic tx_clk = 1'b0,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  // Receive
  output logic rx_clk = 1'b0,
  output logic [3:0] rxd = 4'h0,
  output logic rx_dv = 1'b0,
  output logic rx_er = 1'b0
);
  logic [63:0] frame_q = '0;
  logic [4:0] turn_q = 5'h00;
  logic [4:0] tx_q[$];
  always #24 tx_clk = ~tx_clk;
  initial #7 forever #24 rx_clk = ~rx_clk;
  always @(posedge mdc) frame_q <= {frame_q[62:0], mdio_wire};
  // A read frame is recognised by its start and opcode when the device lets go.
  always @(posedge mdio_oe_n) if (frame_q[13:10] == 4'h6) turn_q <= 5'h01;
  always @(negedge mdc) if (turn_q != 5'h00 && turn_q < 5'h13) turn_q <= turn_q + 5'h01;
  assign phy_drive = mdio_oe_n && turn_q >= 5'h02 && turn_q <= 5'h12;
  assign phy_bit = turn_q == 5'h02 ? 1'b0 : READ_VALUE[5'h12 - turn_q];
  // Underrun filler is dropped so the queue holds only real words.
  always @(posedge tx_clk) begin
    if (tx_en && !(tx_er && txd == 4'h0)) tx_q.push_back({txd, tx_er});
  end
  task automatic rx_nib(input logic [3:0] n, input logic e);
    @(posedge rx_clk);
    #1 rxd = n;
    rx_dv = 1'b1;
    rx_er = e;
    @(posedge rx_clk);
    #1 rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = ~n;
    repeat (20) @(posedge rx_clk);
  endtask
endmodule // mii_phy_model

// >>> verification/tb_top.sv
// Self-checking bench for the MII pin block with a behavioural PHY.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module tb_top;
  import mii_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic single_bit_serial_coding_mode = 1'b0;
  logic tx_in_valid = 1'b0;
  logic rx_out_ready = 1'b1;
  logic mgmt_start = 1'b0;
  logic col = 1'b0;
  logic crs = 1'b0;
  nib_word_type tx_in_word = '0;
  mgmt_cmd_type mgmt_cmd = '0;
  nib_word_type rx_out_word;
  nib_word_type rxq[$];
  logic tx_in_ready, rx_out_valid, mgmt_busy, mgmt_done, col_sync, crs_sync, mdc, mdio_out;
  logic mdio_oe_n, mdw, pd, pb, tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er;
  logic [3:0] txd, rxd;
  logic [15:0] mgmt_rdata;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  assign mdw = !mdio_oe_n ? mdio_out : (pd ? pb : 1'b1);
  mii_mac_pin_interface i_dut (.mclk, .rst_n, .single_bit_serial_coding_mode, .tx_in_valid,
    .tx_in_word, .tx_in_ready, .rx_out_valid, .rx_out_word, .rx_out_ready, .mgmt_start,
    .mgmt_cmd, .mgmt_busy, .mgmt_done, .mgmt_rdata, .col_sync, .crs_sync, .mdc,
    .mdio_in(mdw), .mdio_out, .mdio_oe_n, .tx_clk, .txd, .tx_en, .tx_er, .col, .crs,
    .rx_clk, .rxd, .rx_dv, .rx_er);
  mii_phy_model i_phy (.mdc, .mdio_oe_n, .mdio_wire(mdw), .phy_drive(pd), .phy_bit(pb),
    .tx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er);
  task automatic results;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Words are logged between edges, where the handshake signals have settled.
  always @(negedge mclk) begin
    if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) rxq.push_back(rx_out_word);
  end
  // The hang limit is about fifty times the longest expected run.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic mgmt(input logic w, input logic [15:0] wd);
    logic [15:0] d;
    d = w ? wd : i_phy.READ_VALUE;
    @(posedge mclk);
    #1 mgmt_cmd = '{w, 5'h11, 5'h0A, wd};
    mgmt_start = 1'b1;
    @(posedge mclk);
    #1 mgmt_start = 1'b0;
    repeat (20) @(posedge mclk);
    // A second start while busy must leave the running frame untouched.
    #1 mgmt_cmd = '{!w, 5'h02, 5'h1F, ~wd};
    mgmt_start = 1'b1;
    @(posedge mclk);
    #1 mgmt_start = 1'b0;
    for (int i = 0; i < 400 && mgmt_done !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(mgmt_done, 1'b1);
    chk(i_phy.frame_q, {PREAMBLE, START_CODE, w ? OP_WRITE : OP_READ, 5'h11, 5'h0A, TURNAROUND, d});
    if (!w) chk(mgmt_rdata, d);
  endtask
  task automatic tx(input logic m);
    logic [5:0] w [4];
    w = '{6'h24, 6'h0D, 6'h30, 6'h1E};
    @(posedge mclk);
    #1 single_bit_serial_coding_mode = m;
    i_phy.tx_q.delete();
    repeat (8) @(posedge mclk);
    #1;
    // Ready is a register, so its value just after an edge holds at the next edge.
    foreach (w[i]) begin
      tx_in_valid = 1'b1;
      tx_in_word = w[i];
      while (tx_in_ready !== 1'b1) begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
    end
    tx_in_valid = 1'b0;
    repeat (60) @(posedge mclk);
    chk(i_phy.tx_q.size(), 4);
    foreach (w[i]) chk(i_phy.tx_q[i], {m ? {3'h0, w[i][2]} : w[i][5:2], w[i][0]});
  endtask
  task automatic rx(input logic m);
    @(posedge mclk);
    #1 single_bit_serial_coding_mode = m;
    rx_out_ready = 1'b0;
    rxq.delete();
    repeat (8) @(posedge mclk);
    i_phy.rx_nib(4'hA, 1'b0);
    i_phy.rx_nib(4'h5, 1'b1);
    @(posedge mclk);
    #1 rx_out_ready = 1'b1;
    repeat (20) @(posedge mclk);
    chk(rxq.size(), 2);
    chk(rxq[0], {m ? 4'h0 : 4'hA, 2'h2});
    chk(rxq[1], {m ? 4'h1 : 4'h5, 2'h3});
  endtask
  task automatic status;
    @(posedge mclk);
    #1 col = 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk({col_sync, crs_sync}, 2'h2);
    col = 1'b0;
    crs = 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk({col_sync, crs_sync}, 2'h1);
    crs = 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk({col_sync, crs_sync}, 2'h0);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    mgmt(1'b1, 16'h3C5A);
    mgmt(1'b0, 16'h0000);
    tx(1'b0);
    tx(1'b1);
    rx(1'b0);
    rx(1'b1);
    status();
    results();
  end
endmodule // tb_top
